// file: rtl/sdl_top.sv
`timescale 1ns/1ps
module sdl_top
    import sdl_pkg::*;
(
    // Core clock, also the transmit reference clock, and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // Serial bit clock of the link
    input wire logic LINK_BIT_CLK,
    // Parallel transmit side
    input wire logic [15:0] TX_PARALLEL_WORD,
    input wire logic TX_KCHAR_LOW_FLAG,
    input wire logic TX_KCHAR_HIGH_FLAG,
    // Control and analog status pins
    input wire logic DEVICE_ENABLE,
    input wire logic INTERNAL_LOOPBACK_SELECT,
    input wire logic LOCK_TO_REFERENCE_N,
    input wire logic RX_AMPLITUDE_OK,
    // Serial pins
    input wire logic SERIAL_RX_IN,
    output logic SERIAL_TX_POS,
    output logic SERIAL_TX_NEG,
    output logic SERIAL_TX_OE_N,
    // Parallel receive side
    output logic [15:0] RX_PARALLEL_WORD,
    output logic RX_KCHAR_LOW_FLAG,
    output logic RX_KCHAR_HIGH_FLAG,
    output logic RX_RECOVERED_CLOCK,
    output logic RX_BUS_OE_N,
    // Status
    output logic SIGNAL_ABSENT_DETECT
);

    typedef struct packed {
        logic [POR_CNT_W-1:0] por_cnt;
        logic run;
        logic loop;
        logic lock_n;
        logic signal_absent_detect;
        logic [15:0] tx_word;
        logic tx_klo;
        logic tx_khi;
        logic rd;
        logic [CODE_W-1:0] tx_hold;
        logic tx_tog;
    } sdl_core_t;

    typedef struct packed {
        logic rx_m;
        logic rx_s;
        logic [4:0] tx_cnt;
        logic [CODE_W-1:0] tx_sh;
        logic seen;
        logic tx_bit;
        logic tx_neg;
        logic tx_oe_n;
        logic [CODE_W-1:0] rx_sh;
        logic [4:0] rx_cnt;
        logic aligned;
        logic [15:0] rx_word;
        logic rx_klo;
        logic rx_khi;
        logic rx_clk;
        logic rx_oe_n;
    } sdl_link_t;

    localparam sdl_link_t LINK_RST = '{tx_oe_n: 1'b1, rx_oe_n: 1'b1, default: '0};

    sdl_core_t c_reg;
    sdl_core_t c_next;
    sdl_link_t l_reg;
    sdl_link_t l_next;
    logic rst_n;
    logic lrst_n;
    logic en_s;
    logic loop_s;
    logic lock_n_s;
    logic amp_low_s;
    logic ack_s;
    logic lv_run;
    logic lv_loop;
    logic lv_lock_n;
    logic lv_los;
    logic lv_tog;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and domain crossings

    sdl_sync #(.W(1)) u_crst (.clk(CORE_CLK), .arst_n(NRST), .d(1'b1), .q(rst_n));
    sdl_sync #(.W(1)) u_lrst (.clk(LINK_BIT_CLK), .arst_n(NRST), .d(1'b1), .q(lrst_n));

    // Amplitude synced as a low flag so the cleared stages never fake a loss
    sdl_sync #(.W(5)) u_csync (
        .clk(CORE_CLK),
        .arst_n(rst_n),
        .d({DEVICE_ENABLE, INTERNAL_LOOPBACK_SELECT, LOCK_TO_REFERENCE_N,
            !RX_AMPLITUDE_OK, l_reg.seen}),
        .q({en_s, loop_s, lock_n_s, amp_low_s, ack_s})
    );

    // Hold word is only read after its toggle lands, and stays put until acked
    sdl_sync #(.W(5)) u_lsync (
        .clk(LINK_BIT_CLK),
        .arst_n(lrst_n),
        .d({c_reg.run, c_reg.loop, c_reg.lock_n, c_reg.signal_absent_detect, c_reg.tx_tog}),
        .q({lv_run, lv_loop, lv_lock_n, lv_los, lv_tog})
    );

    ////////////////////////////////////////////////////////////////////////
    // Core domain: power-on reset, capture and encode

    always_comb begin
        logic [10:0] e_lo;
        logic [10:0] e_hi;
        e_lo = sdl_enc(c_reg.tx_word[7:0], c_reg.tx_klo, c_reg.rd);
        e_hi = sdl_enc(c_reg.tx_word[15:8], c_reg.tx_khi, e_lo[10]);
        c_next = c_reg;
        // RULE13 enable restarts por
        if (!en_s) begin
            c_next.por_cnt = '0;
        end else if (c_reg.por_cnt != POR_CYCLES) begin
            c_next.por_cnt = c_reg.por_cnt + POR_CNT_W'(1);
        end
        // RULE10 run after por
        c_next.run = en_s && (c_reg.por_cnt == POR_CYCLES);
        c_next.loop = loop_s;
        c_next.lock_n = lock_n_s;
        // RULE7 loss of signal
        c_next.signal_absent_detect = amp_low_s;
        // RULE1 capture every cycle
        c_next.tx_word = TX_PARALLEL_WORD;
        // RULE14 per-byte K flags
        c_next.tx_klo = TX_KCHAR_LOW_FLAG;
        c_next.tx_khi = TX_KCHAR_HIGH_FLAG;
        if (!c_reg.run) begin
            c_next.rd = RD_RESET;
        end else if (c_reg.tx_tog == ack_s) begin
            // RULE2 two bytes encoded
            c_next.tx_hold = {e_lo[9:0], e_hi[9:0]};
            c_next.rd = e_hi[10];
            c_next.tx_tog = !c_reg.tx_tog;
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            c_reg <= '0;
        end else begin
            c_reg <= c_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link domain: serializer, deserializer, aligner, decoder

    always_comb begin
        logic [CODE_W-1:0] sh_cur;
        logic [CODE_W-1:0] nsh;
        logic [4:0] idx;
        logic rx_bit;
        logic comma;
        logic [8:0] d_lo;
        logic [8:0] d_hi;
        sh_cur = l_reg.tx_sh;
        nsh = '0;
        idx = l_reg.rx_cnt;
        rx_bit = 1'b0;
        comma = 1'b0;
        d_lo = '0;
        d_hi = '0;
        l_next = l_reg;
        l_next.rx_m = SERIAL_RX_IN;
        l_next.rx_s = l_reg.rx_m;

        if (!lv_run) begin
            // RULE10 serial pins float
            l_next.tx_cnt = '0;
            l_next.tx_bit = 1'b0;
            l_next.tx_neg = 1'b0;
            l_next.tx_oe_n = 1'b1;
        end else begin
            if (l_reg.tx_cnt == 5'h00) begin
                sh_cur = (lv_tog != l_reg.seen) ? c_reg.tx_hold : IDLE_PAIR;
                l_next.seen = lv_tog;
            end
            // RULE3 twenty bits per word
            l_next.tx_bit = sh_cur[CODE_W-1];
            l_next.tx_neg = !sh_cur[CODE_W-1];
            l_next.tx_sh = {sh_cur[CODE_W-2:0], 1'b0};
            l_next.tx_cnt = (l_reg.tx_cnt == BIT_LAST) ? 5'h00 : l_reg.tx_cnt + 5'h01;
            // RULE11 float in loopback
            l_next.tx_oe_n = lv_loop;
        end

        // RULE6 loopback path
        rx_bit = lv_loop ? l_reg.tx_bit : l_reg.rx_s;
        nsh = {l_reg.rx_sh[CODE_W-2:0], rx_bit};
        comma = (nsh[9:3] == COMMA_NEG) || (nsh[9:3] == COMMA_POS);

        // RULE8 float receive side, stop tracking
        if (!lv_run || !lv_lock_n) begin
            l_next.rx_oe_n = 1'b1;
            l_next.rx_clk = 1'b0;
            l_next.aligned = 1'b0;
            l_next.rx_cnt = '0;
        end else begin
            // RULE9 single bus driver
            l_next.rx_oe_n = 1'b0;
            l_next.rx_sh = nsh;
            // RULE15 comma sets group boundary
            if (comma && (idx != LO_GROUP_LAST) && (idx != BIT_LAST)) begin
                idx = LO_GROUP_LAST;
            end
            if (comma) begin
                l_next.aligned = 1'b1;
            end else if (lv_los) begin
                l_next.aligned = 1'b0;
            end
            l_next.rx_cnt = (idx == BIT_LAST) ? 5'h00 : idx + 5'h01;
            // RULE4 recovered clock
            l_next.rx_clk = l_reg.aligned && (idx >= RCLK_RISE) && (idx < RCLK_FALL);
            if (l_reg.aligned && (idx == BIT_LAST)) begin
                // RULE5 decode 20 to 16
                d_lo = sdl_dec(nsh[19:10]);
                d_hi = sdl_dec(nsh[9:0]);
                l_next.rx_word = {d_hi[7:0], d_lo[7:0]};
                // RULE12 low-byte K flag
                l_next.rx_klo = d_lo[8];
                l_next.rx_khi = d_hi[8];
            end
        end
    end

    always_ff @(posedge LINK_BIT_CLK or negedge lrst_n) begin
        if (!lrst_n) begin
            l_reg <= LINK_RST;
        end else begin
            l_reg <= l_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops

    assign SERIAL_TX_POS = l_reg.tx_bit;
    assign SERIAL_TX_NEG = l_reg.tx_neg;
    assign SERIAL_TX_OE_N = l_reg.tx_oe_n;
    assign RX_PARALLEL_WORD = l_reg.rx_word;
    assign RX_KCHAR_LOW_FLAG = l_reg.rx_klo;
    assign RX_KCHAR_HIGH_FLAG = l_reg.rx_khi;
    assign RX_RECOVERED_CLOCK = l_reg.rx_clk;
    assign RX_BUS_OE_N = l_reg.rx_oe_n;
    // Signal detect stays alive in power-down
    assign SIGNAL_ABSENT_DETECT = c_reg.signal_absent_detect;

endmodule : sdl_top

// file: rtl/sdl_pkg.sv
// Contract
// RULE1: Capture one 16-bit transmit word every transmit reference clock cycle.
// RULE2: Encode each word into 20 bits, each byte 8b/10b separately; the code encodes only the word held when the link acks the last code.
// RULE3: Shift the 20-bit code out serially, twenty bits per reference word.
// RULE4: Deserialize received bits into 20-bit words and output a recovered clock.
// RULE5: Decode each 20-bit word into 16 bits timed by the recovered clock.
// RULE6: Loopback routes serializer output straight into the deserializer.
// RULE7: Flag loss of signal when received amplitude is too small.
// RULE8: Lock-to-reference low floats receive bus, recovered clock and K flags; the code holds the recovered clock low instead.
// RULE9: Shared receive buses keep lock-to-reference low on all but one device.
// RULE10: Power-on reset holds recovered clock low and floats parallel and serial outputs.
// RULE11: Loopback holds both serial transmit outputs in high impedance.
// RULE12: Low-byte receive K flag is high for control, low for data.
// RULE13: Enable low powers down except signal detect; rising enable reruns power-on reset.
// RULE14: Protocol device drives per-byte transmit K flags with each word.
// RULE15: Comma characters align the 10-bit code-group boundaries before decoding.
package sdl_pkg;

    localparam int WORD_W = 16;
    localparam int CODE_W = 20;
    localparam int CORE_CLK_PERIOD_NS = 50;
    localparam int POR_TIME_NS = 1000;
    localparam int POR_CYC_RAW = (POR_TIME_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam int POR_CNT_W = 5;
    localparam logic [POR_CNT_W-1:0] POR_CYCLES =
        POR_CNT_W'((POR_CYC_RAW < 1) ? 1 : POR_CYC_RAW);
    localparam logic [4:0] BIT_LAST = 5'h13;
    localparam logic [4:0] LO_GROUP_LAST = 5'h09;
    localparam logic [4:0] RCLK_RISE = 5'h04;
    localparam logic [4:0] RCLK_FALL = 5'h0e;
    localparam logic RD_RESET = 1'b0;

    // K28.5 negative then positive: net balanced, so idle keeps disparity intact
    localparam logic [19:0] IDLE_PAIR = 20'h3eb05;
    localparam logic [6:0] COMMA_NEG = 7'h1f;
    localparam logic [6:0] COMMA_POS = 7'h60;
    localparam logic [5:0] K28_6B = 6'h0f;
    localparam logic [3:0] A7_4B = 4'h7;
    localparam logic [3:0] X3_4B = 4'hc;
    localparam logic [5:0] D7_6B = 6'h38;

    // Codes for negative disparity, abcdei and fghj, first bit in MSB
    localparam logic [5:0] T6 [0:31] = '{
        6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
        6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] T4 [0:7] = '{
        4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

    // Returns {new disparity, abcdei, fghj}
    function automatic logic [10:0] sdl_enc(input logic [7:0] d, input logic k,
                                            input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic r;
        logic k28;
        k28 = k && (d[4:0] == 5'h1c);
        s6 = k28 ? K28_6B : T6[d[4:0]];
        r = rd;
        if (r && (($countones(s6) != 3) || (s6 == D7_6B))) begin
            s6 = ~s6;
        end
        if ($countones(s6) != 3) begin
            r = ~r;
        end
        s4 = T4[d[7:5]];
        if ((d[7:5] == 3'h7) && (k || (!r && s6[1:0] == 2'h3) || (r && s6[1:0] == 2'h0))) begin
            s4 = A7_4B;
        end
        if (k28 && !r && ($countones(s4) == 2) && (s4 != X3_4B)) begin
            s4 = ~s4;
        end
        if (r && (($countones(s4) != 2) || (s4 == X3_4B))) begin
            s4 = ~s4;
        end
        if ($countones(s4) != 2) begin
            r = ~r;
        end
        return {r, s6, s4};
    endfunction : sdl_enc

    // Returns {K flag, byte}; unknown groups decode as zero fields
    function automatic logic [8:0] sdl_dec(input logic [9:0] g);
        logic [5:0] s6;
        logic [3:0] s4;
        logic [4:0] x;
        logic [2:0] y;
        logic k;
        s6 = g[9:4];
        s4 = g[3:0];
        x = 5'h00;
        y = 3'h0;
        k = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if ((s6 == T6[i]) || ((s6 == ~T6[i]) && (($countones(T6[i]) != 3) || i == 7))) begin
                x = 5'(i);
            end
        end
        if ((s6 == K28_6B) || (s6 == ~K28_6B)) begin
            x = 5'h1c;
            k = 1'b1;
            if ((s6 == ~K28_6B) && ($countones(s4) == 2) && (s4 != X3_4B) && (s4 != ~X3_4B)) begin
                s4 = ~s4;
            end
        end
        for (int j = 0; j < 8; j++) begin
            if ((s4 == T4[j]) || ((s4 == ~T4[j]) && (($countones(T4[j]) != 2) || j == 3))) begin
                y = 3'(j);
            end
        end
        if ((s4 == A7_4B) || (s4 == ~A7_4B)) begin
            y = 3'h7;
            if ((x == 5'h17) || (x == 5'h1b) || (x == 5'h1d) || (x == 5'h1e)) begin
                k = 1'b1;
            end
        end
        return {k, y, x};
    endfunction : sdl_dec

endpackage : sdl_pkg

// file: rtl/sdl_sync.sv
`timescale 1ns/1ps
module sdl_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Level in, synchronised level out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] m;
        logic [W-1:0] s;
    } sdl_sync_t;

    sdl_sync_t st_reg;
    sdl_sync_t st_next;

    always_comb begin
        st_next.m = d;
        st_next.s = st_reg.m;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s;
endmodule : sdl_sync

// file: test/sdl_top_chk.sv
`timescale 1ns/1ps
module sdl_chk (
    // Clocks and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic LINK_BIT_CLK,
    // Control pins
    input wire logic DEVICE_ENABLE,
    input wire logic INTERNAL_LOOPBACK_SELECT,
    input wire logic LOCK_TO_REFERENCE_N,
    input wire logic RX_AMPLITUDE_OK,
    // Outputs
    input wire logic SERIAL_TX_POS,
    input wire logic SERIAL_TX_NEG,
    input wire logic SERIAL_TX_OE_N,
    input wire logic [15:0] RX_PARALLEL_WORD,
    input wire logic RX_RECOVERED_CLOCK,
    input wire logic RX_BUS_OE_N,
    input wire logic SIGNAL_ABSENT_DETECT
);
    // Long enough to cover both synchronisers
    sequence s_loop_held;
        INTERNAL_LOOPBACK_SELECT[*8];
    endsequence
    sequence s_lock_low;
        (!LOCK_TO_REFERENCE_N)[*8];
    endsequence
    sequence s_off;
        (!DEVICE_ENABLE)[*8];
    endsequence
    sequence s_floating;
        (SERIAL_TX_OE_N && RX_BUS_OE_N && !RX_RECOVERED_CLOCK)[*8];
    endsequence
    property p_por;
        @(posedge CORE_CLK) disable iff (!NRST) $rose(NRST) |-> s_floating;
    endproperty
    property p_por_en;
        @(posedge CORE_CLK) disable iff (!NRST)
            $rose(DEVICE_ENABLE) && SERIAL_TX_OE_N && RX_BUS_OE_N |-> s_floating;
    endproperty
    property p_off;
        @(posedge CORE_CLK) disable iff (!NRST) s_off |-> SERIAL_TX_OE_N && RX_BUS_OE_N;
    endproperty
    property p_loop;
        @(posedge CORE_CLK) disable iff (!NRST) s_loop_held |-> SERIAL_TX_OE_N;
    endproperty
    property p_lock;
        @(posedge CORE_CLK) disable iff (!NRST)
            s_lock_low |-> RX_BUS_OE_N && !RX_RECOVERED_CLOCK;
    endproperty
    property p_los_set;
        @(posedge CORE_CLK) disable iff (!NRST) (!RX_AMPLITUDE_OK)[*6] |-> SIGNAL_ABSENT_DETECT;
    endproperty
    property p_los_clr;
        @(posedge CORE_CLK) disable iff (!NRST) RX_AMPLITUDE_OK[*6] |-> !SIGNAL_ABSENT_DETECT;
    endproperty
    property p_pair;
        @(posedge LINK_BIT_CLK) disable iff (!NRST)
            !SERIAL_TX_OE_N |-> SERIAL_TX_NEG != SERIAL_TX_POS;
    endproperty
    property p_word_hold;
        @(posedge LINK_BIT_CLK) disable iff (!NRST)
            RX_RECOVERED_CLOCK && $past(RX_RECOVERED_CLOCK) |-> $stable(RX_PARALLEL_WORD);
    endproperty
    a_por: assert property (p_por) else $error("outputs driven during power-on");
    a_por_en: assert property (p_por_en) else $error("no reset after enable");
    a_off: assert property (p_off) else $error("outputs driven in power-down");
    a_loop: assert property (p_loop) else $error("tx driven in loopback");
    a_lock: assert property (p_lock) else $error("rx bus driven with lock low");
    a_los_set: assert property (p_los_set) else $error("loss not flagged");
    a_los_clr: assert property (p_los_clr) else $error("loss flag stuck");
    a_pair: assert property (p_pair) else $error("tx pair not complementary");
    a_word_hold: assert property (p_word_hold) else $error("rx word moved");
endmodule : sdl_chk
bind sdl_top sdl_chk i_chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .LINK_BIT_CLK(LINK_BIT_CLK),
    .DEVICE_ENABLE(DEVICE_ENABLE), .INTERNAL_LOOPBACK_SELECT(INTERNAL_LOOPBACK_SELECT),
    .LOCK_TO_REFERENCE_N(LOCK_TO_REFERENCE_N), .RX_AMPLITUDE_OK(RX_AMPLITUDE_OK),
    .SERIAL_TX_POS(SERIAL_TX_POS), .SERIAL_TX_NEG(SERIAL_TX_NEG),
    .SERIAL_TX_OE_N(SERIAL_TX_OE_N), .RX_PARALLEL_WORD(RX_PARALLEL_WORD),
    .RX_RECOVERED_CLOCK(RX_RECOVERED_CLOCK), .RX_BUS_OE_N(RX_BUS_OE_N),
    .SIGNAL_ABSENT_DETECT(SIGNAL_ABSENT_DETECT));

// file: test/sdl_proto_model.sv
`timescale 1ns/1ps
module sdl_proto_model (
    // Core clock and next word {kh, kl, word}
    input wire logic clk,
    input wire logic [17:0] send,
    // Transmit side
    output logic [15:0] tx_word,
    output logic tx_kl,
    output logic tx_kh,
    // Receive side
    input wire logic rclk,
    input wire logic bus_oe_n,
    input wire logic [17:0] rx_in,
    output logic [17:0] seen
);
    initial begin
        {tx_kh, tx_kl, tx_word} = 18'h0;
        seen = 18'h0;
    end
    always @(posedge clk) begin
        #1;
        {tx_kh, tx_kl, tx_word} = send;
    end
    always @(posedge rclk) begin
        if (bus_oe_n === 1'b0) begin
            seen = rx_in;
        end
    end
endmodule : sdl_proto_model

// file: test/test_serdes_8b10b_link.sv
`timescale 1ns/1ps
module test_serdes_8b10b_link;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic nrst = 1'b0;
    logic en = 1'b1;
    logic loop_sel = 1'b0;
    logic lock_n = 1'b1;
    logic amp_ok = 1'b1;
    logic rx_in = 1'b0;
    logic [17:0] send = 18'h0;
    logic [17:0] seen;
    logic [15:0] txw;
    logic [15:0] rxw;
    logic tkl, tkh, rkl, rkh, tx_p, tx_n, tx_oe_n, rclk, rx_oe_n, signal_absent_detect;
    logic [31:0] rng = 32'h5ea914a7;
    logic [17:0] exp_q [$];
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    always #25 core_clk = ~core_clk;
    initial #3.7 forever #6 link_clk = ~link_clk;
    // Released line toggles so a stale bit never looks valid
    always @(posedge link_clk) begin
        #1;
        rx_in = tx_oe_n ? ~rx_in : tx_p;
    end
    sdl_top i_dut (.CORE_CLK(core_clk), .NRST(nrst), .LINK_BIT_CLK(link_clk),
        .TX_PARALLEL_WORD(txw), .TX_KCHAR_LOW_FLAG(tkl), .TX_KCHAR_HIGH_FLAG(tkh),
        .DEVICE_ENABLE(en), .INTERNAL_LOOPBACK_SELECT(loop_sel),
        .LOCK_TO_REFERENCE_N(lock_n), .RX_AMPLITUDE_OK(amp_ok), .SERIAL_RX_IN(rx_in),
        .SERIAL_TX_POS(tx_p), .SERIAL_TX_NEG(tx_n), .SERIAL_TX_OE_N(tx_oe_n),
        .RX_PARALLEL_WORD(rxw), .RX_KCHAR_LOW_FLAG(rkl), .RX_KCHAR_HIGH_FLAG(rkh),
        .RX_RECOVERED_CLOCK(rclk), .RX_BUS_OE_N(rx_oe_n), .SIGNAL_ABSENT_DETECT(signal_absent_detect));
    sdl_proto_model i_proto (.clk(core_clk), .send(send), .tx_word(txw), .tx_kl(tkl),
        .tx_kh(tkh), .rclk(rclk), .bus_oe_n(rx_oe_n), .rx_in({rkh, rkl, rxw}), .seen(seen));
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [17:0] got, input logic [17:0] want);
        total_checks++;
        if (got !== want) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask : check
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : ticks
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // Comma word first so the receiver realigns, then the word under test
    task automatic xfer(input logic [17:0] w);
        send = 18'h100bc;
        ticks(16);
        exp_q.push_back(w);
        send = w;
        ticks(30);
        check(seen, exp_q.pop_front());
    endtask : xfer
    task automatic xfer_rand();
        rng = xs(rng);
        xfer({2'b00, rng[15:0]});
    endtask : xfer_rand
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ticks(11);
        check(18'({tx_oe_n, rx_oe_n, rclk}), 18'h6);
        ticks(1);
        nrst = 1'b1;
        ticks(4);
        check(18'(signal_absent_detect), 18'h0);
        ticks(4);
        check(18'({tx_oe_n, rx_oe_n, rclk}), 18'h6);
        ticks(30);
        check(18'({tx_oe_n, rx_oe_n}), 18'h0);
        $display("power-on test done");
        for (int i = 0; i < 4; i++) begin
            xfer_rand();
        end
        xfer(18'h3f7bc);
        xfer(18'h000bc);
        $display("link test done");
        loop_sel = 1'b1;
        ticks(10);
        check(18'(tx_oe_n), 18'h1);
        xfer_rand();
        loop_sel = 1'b0;
        $display("loopback test done");
        lock_n = 1'b0;
        ticks(10);
        check(18'({rx_oe_n, rclk}), 18'h2);
        lock_n = 1'b1;
        xfer_rand();
        $display("lock test done");
        amp_ok = 1'b0;
        ticks(6);
        check(18'(signal_absent_detect), 18'h1);
        amp_ok = 1'b1;
        ticks(6);
        check(18'(signal_absent_detect), 18'h0);
        xfer_rand();
        $display("signal loss test done");
        en = 1'b0;
        ticks(10);
        check(18'({tx_oe_n, rx_oe_n, rclk}), 18'h6);
        en = 1'b1;
        ticks(12);
        check(18'({tx_oe_n, rx_oe_n, rclk}), 18'h6);
        ticks(20);
        xfer_rand();
        $display("enable test done");
        final_report();
    end
endmodule : test_serdes_8b10b_link
